// ### logic/tsa_map.vh
/*
 tsa_map.vh: command codes, state codes and field widths for the tag
 state and anticollision block. assumes a command decoder that presents
 one of these codes with a one-cycle valid strobe.
*/
`ifndef TSA_MAP_VH
`define TSA_MAP_VH

`define TSA_ID_W         8
`define TSA_SLOT_W       4
`define TSA_CMD_W        4
`define TSA_LFSR_W       16
`define TSA_LFSR_SEED    16'hACE1
`define TSA_LFSR_TAPS    16'hB400

`define TSA_CMD_INV_OPEN 4'h1
`define TSA_CMD_SLOT0    4'h2
`define TSA_CMD_SLOT     4'h3
`define TSA_CMD_PICK     4'h4
`define TSA_CMD_RETIRE   4'h5
`define TSA_CMD_RD_BLK   4'h6
`define TSA_CMD_WR_BLK   4'h7
`define TSA_CMD_AUTH     4'h8
`define TSA_CMD_UID      4'h9

`define TSA_ST_READY     5'h01
`define TSA_ST_INV       5'h02
`define TSA_ST_SEL       5'h04
`define TSA_ST_DESEL     5'h08
`define TSA_ST_DEACT     5'h10

`endif

// ### logic/tsa_core.v
/*
 tsa_core.v: state machine and slotted anticollision of a contactless
 tag. consumes decoded, crc-checked commands from the frame decoder and
 issues reply requests to the frame encoder. sys_rst is the field
 power-up reset, applied asynchronously; all other inputs are synchronous to clk.
*/
`timescale 1ns/1ps
`include "tsa_map.vh"

// Overview of operation
// - power-up resets logic, ready, identifier from the lfsr seed's low byte
// - ready ignores everything but inventory-open
// - inventory-open in ready enters inventory
// - inventory answers open and polls, stays
// - matching pick in inventory selects tag
// - selected executes read, write, auth, uid
// - selected stops answering anticollision commands
// - foreign pick deselects; retire deactivates
// - deselected returns only on matching pick
// - deactivated ignores all until power loss
// - identifier is eight bits wide
// - inventory-open in inventory redraws identifier
// - low four identifier bits are slot selector
// - slot-zero poll redraws selector, replies if zero
// - slot poll replies when index equals selector
// - sixteen slots: zero poll then 1..15
// - inventory-open reply needs no slot
// - one slot reply per anticollision sequence, plus the open reply
// - invalid frame gives no reply, no error
module tsa_core
#(
   parameter ID_W   = `TSA_ID_W,
   parameter SLOT_W = `TSA_SLOT_W
)
(
   input  wire                  clk,
   input  wire                  sys_rst,
   input  wire                  cmd_valid,
   input  wire [`TSA_CMD_W-1:0] cmd_code,
   input  wire                  cmd_crc_ok,
   input  wire [ID_W-1:0]       cmd_pick_id,
   input  wire [SLOT_W-1:0]     slot_index_param,
   output reg                   id_reply,
   output reg  [ID_W-1:0]       id_reply_data,
   output reg                   mem_cmd_go,
   output reg  [`TSA_CMD_W-1:0] mem_cmd_code,
   output reg  [4:0]            tag_state,
   output reg  [ID_W-1:0]       tag_identifier
);

   reg [`TSA_LFSR_W-1:0] lfsr_r;
   reg [4:0]             state_r;
   reg [4:0]             state_nxt;
   reg [ID_W-1:0]        id_nxt;
   reg                   replied_r;
   reg                   replied_nxt;
   reg                   reply_nxt;
   reg                   go_nxt;
   wire                  cmd_ok;
   wire                  pick_hit;
   wire [SLOT_W-1:0]     rnd_slot;

   // an invalid frame is dropped here, so no state change, no reply
   assign cmd_ok   = cmd_valid & cmd_crc_ok;
   assign pick_hit = (cmd_pick_id == tag_identifier);
   assign rnd_slot = lfsr_r[SLOT_W-1:0];

   // galois lfsr runs every cycle, so draw timing is unpredictable
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         lfsr_r <= `TSA_LFSR_SEED;
      else if (lfsr_r[0])
         lfsr_r <= (lfsr_r >> 1) ^ `TSA_LFSR_TAPS;
      else
         lfsr_r <= lfsr_r >> 1;
   end

   always @*
   begin
      state_nxt   = state_r;
      id_nxt      = tag_identifier;
      replied_nxt = replied_r;
      reply_nxt   = 1'b0;
      go_nxt      = 1'b0;
      if (cmd_ok)
      begin
         case (state_r)
            `TSA_ST_READY:
            begin
               // everything else is silently ignored
               if (cmd_code == `TSA_CMD_INV_OPEN)
               begin
                  state_nxt   = `TSA_ST_INV;
                  id_nxt      = lfsr_r[ID_W-1:0];
                  reply_nxt   = 1'b1;
                  replied_nxt = 1'b0;
               end
            end
            `TSA_ST_INV:
            begin
               case (cmd_code)
                  `TSA_CMD_INV_OPEN:
                  begin
                     // a new sequence starts; fresh id, reply again
                     id_nxt      = lfsr_r[ID_W-1:0];
                     reply_nxt   = 1'b1;
                     replied_nxt = 1'b0;
                  end
                  `TSA_CMD_SLOT0:
                  begin
                     // keep upper id bits, redraw the slot selector
                     id_nxt = {tag_identifier[ID_W-1:SLOT_W], rnd_slot};
                     if (rnd_slot == {SLOT_W{1'b0}} && !replied_r)
                     begin
                        reply_nxt   = 1'b1;
                        replied_nxt = 1'b1;
                     end
                  end
                  `TSA_CMD_SLOT:
                  begin
                     // index 0 is not a marker slot; slot 0 is the zero poll
                     if (slot_index_param != {SLOT_W{1'b0}} &&
                         slot_index_param == tag_identifier[SLOT_W-1:0] &&
                         !replied_r)
                     begin
                        reply_nxt   = 1'b1;
                        replied_nxt = 1'b1;
                     end
                  end
                  `TSA_CMD_PICK:
                  begin
                     if (pick_hit)
                        state_nxt = `TSA_ST_SEL;
                  end
                  default:
                  begin
                     state_nxt = state_r;
                  end
               endcase
            end
            `TSA_ST_SEL:
            begin
               // anticollision commands fall to default: no reply
               case (cmd_code)
                  `TSA_CMD_RD_BLK,
                  `TSA_CMD_WR_BLK,
                  `TSA_CMD_AUTH,
                  `TSA_CMD_UID:
                     go_nxt = 1'b1;
                  `TSA_CMD_PICK:
                  begin
                     // reader keeps one tag selected; a match stays here
                     if (!pick_hit)
                        state_nxt = `TSA_ST_DESEL;
                  end
                  `TSA_CMD_RETIRE:
                     state_nxt = `TSA_ST_DEACT;
                  default:
                     state_nxt = state_r;
               endcase
            end
            `TSA_ST_DESEL:
            begin
               if (cmd_code == `TSA_CMD_PICK && pick_hit)
                  state_nxt = `TSA_ST_SEL;
            end
            `TSA_ST_DEACT:
            begin
               state_nxt = `TSA_ST_DEACT;
            end
            default:
            begin
               state_nxt = `TSA_ST_READY;
            end
         endcase
      end
   end

   // the lfsr value, still the seed, is drawn one cycle after release, since async
   // reset may only load constants
   reg seed_pend_r;

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_r        <= `TSA_ST_READY;
         tag_identifier <= {ID_W{1'b0}};
         seed_pend_r    <= 1'b1;
         replied_r      <= 1'b0;
         id_reply       <= 1'b0;
         id_reply_data  <= {ID_W{1'b0}};
         mem_cmd_go     <= 1'b0;
         mem_cmd_code   <= {`TSA_CMD_W{1'b0}};
         tag_state      <= `TSA_ST_READY;
      end
      else
      begin
         seed_pend_r   <= 1'b0;
         state_r       <= state_nxt;
         replied_r     <= replied_nxt;
         id_reply      <= reply_nxt;
         id_reply_data <= id_nxt;
         mem_cmd_go    <= go_nxt;
         mem_cmd_code  <= cmd_code;
         tag_state     <= state_nxt;
         if (seed_pend_r)
            tag_identifier <= lfsr_r[ID_W-1:0];
         else
            tag_identifier <= id_nxt;
      end
   end

endmodule

// ### sim/tsa_core_asserts.sv
/* tsa_core_asserts.sv: port checker for tsa_core.
 assumes it is bound into tsa_core and sees its ports only. */
`timescale 1ns/1ps
`include "tsa_map.vh"
module tsa_core_asserts
(
   input wire       clk,
   input wire       sys_rst,
   input wire       cmd_valid,
   input wire [3:0] cmd_code,
   input wire       cmd_crc_ok,
   input wire [7:0] cmd_pick_id,
   input wire [3:0] slot_index_param,
   input wire       id_reply,
   input wire       mem_cmd_go,
   input wire [3:0] mem_cmd_code,
   input wire [4:0] tag_state,
   input wire [7:0] tag_identifier
);
   wire tk = cmd_valid & cmd_crc_ok;
   wire pk = cmd_code == `TSA_CMD_PICK;
   wire hit = cmd_pick_id == tag_identifier;
   wire quiet = !id_reply && !mem_cmd_go;
   wire rdy = tag_state == `TSA_ST_READY;
   wire inv = tag_state == `TSA_ST_INV;
   wire sel = tag_state == `TSA_ST_SEL;
   wire des = tag_state == `TSA_ST_DESEL;
   wire dea = tag_state == `TSA_ST_DEACT;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   AST_READY_IGNORE: assert property (rdy && tk && cmd_code != 4'h1
      |=> quiet && rdy) else $error("ready obeyed a command");
   AST_READY_OPEN: assert property (rdy && tk && cmd_code == 4'h1
      |=> inv && id_reply) else $error("open did not enter inventory");
   AST_PICK_SEL: assert property (inv && tk && pk && hit
      |=> sel) else $error("matching pick not selected");
   AST_MEM_GO: assert property (sel && tk && cmd_code > 4'h5
      && cmd_code < 4'hA |=> mem_cmd_go && mem_cmd_code == $past(cmd_code))
      else $error("memory command not issued");
   AST_SEL_MUTE: assert property (sel |=> !id_reply)
      else $error("selected tag replied");
   AST_SEL_AWAY: assert property (sel && tk && pk && !hit |=> des)
      else $error("foreign pick did not deselect");
   AST_RETIRE: assert property (sel && tk && cmd_code == 4'h5 |=> dea)
      else $error("retire did not deactivate");
   AST_DESEL_HOLD: assert property (des && tk && !(pk && hit)
      |=> des && quiet) else $error("deselected tag obeyed");
   AST_DEACT_HOLD: assert property (dea |=> dea && quiet)
      else $error("deactivated tag left or obeyed");
   AST_BAD_FRAME: assert property (cmd_valid && !cmd_crc_ok
      |=> quiet && $stable(tag_state)) else $error("bad frame acted on");
   AST_SLOT_MISS: assert property (inv && tk && cmd_code == 4'h3
      && slot_index_param != tag_identifier[3:0] |=> !id_reply)
      else $error("slot mismatch replied");
endmodule
bind tsa_core tsa_core_asserts u_chk (.*);

// ### sim/tsa_reader_model.sv
/* tsa_reader_model.sv: reader side, one decoded command per send call.
 assumes the caller starts each call just after a rising edge. */
`timescale 1ns/1ps
module tsa_reader_model
(
   input  wire      clk,
   output reg       cmd_valid,
   output reg [3:0] cmd_code,
   output reg       cmd_crc_ok,
   output reg [7:0] cmd_pick_id,
   output reg [3:0] slot_index_param
);
   initial {cmd_valid, cmd_code, cmd_crc_ok, cmd_pick_id} = 14'h0000;
   initial slot_index_param = 4'h0;
   task send(input [3:0] c, input [7:0] id, input [3:0] s, input ok);
   begin
      // one idle edge first, so valid never drops and rises in one step
      @(posedge clk);
      #1;
      {cmd_valid, cmd_code, cmd_pick_id, slot_index_param} = {1'b1, c, id, s};
      cmd_crc_ok = ok;
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      // idle fields scrambled so a stale value is never trusted
      {cmd_code, cmd_pick_id} = ~{cmd_code, cmd_pick_id};
      slot_index_param = ~slot_index_param;
   end
   endtask
endmodule

// ### sim/tsa_core_tb_top.sv
/* tsa_core_tb_top.sv: directed bench for tsa_core.
 assumes the reader model drives commands and the checker is bound. */
`timescale 1ns/1ps
`include "tsa_map.vh"
module tsa_core_tb_top;
   reg        clk = 1'b0;
   reg        sys_rst = 1'b1;
   wire       cmd_valid, cmd_crc_ok, id_reply, mem_cmd_go;
   wire [3:0] cmd_code, slot_index_param, mem_cmd_code;
   wire [7:0] cmd_pick_id, id_reply_data, tag_identifier;
   wire [4:0] tag_state;
   integer    err_total = 0, checks_done = 0, i;
   reg        rep;
   reg  [3:0] sl;
   initial forever #2 clk = ~clk;
   tsa_reader_model u_rdr (.*);
   tsa_core u_dut (.*);
   task chk(input [15:0] g, input [15:0] e);
   begin
      checks_done = checks_done + 1;
      if (g !== e)
      begin
         err_total = err_total + 1;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   end
   endtask
   task close_out;
   begin
      $display("mismatches %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask
   task s_ready;
   begin
      for (i = 2; i < 10; i = i + 1)
      begin
         u_rdr.send(i[3:0], tag_identifier, 4'h0, 1'b1);
         chk({id_reply, mem_cmd_go, tag_state}, 16'h0001);
      end
      u_rdr.send(4'h1, 8'h00, 4'h0, 1'b0);
      chk({id_reply, tag_state}, 16'h0001);
      u_rdr.send(4'h1, 8'h00, 4'h0, 1'b1);
      chk({id_reply, id_reply_data, tag_state}, {1'b1, tag_identifier, 5'h02});
   end
   endtask
   task s_inv;
   begin
      rep = 1'b0;
      for (i = 0; i < 64 && (i == 0 || sl == 4'h0); i = i + 1)
      begin
         u_rdr.send(4'h2, 8'h00, 4'h0, 1'b1);
         sl = tag_identifier[3:0];
         chk(id_reply, sl == 4'h0 && !rep);
         rep = rep | (sl == 4'h0);
      end
      chk(sl == 4'h0, 16'h0000);
      u_rdr.send(4'h3, 8'h00, sl ^ 4'h1, 1'b1);
      chk(id_reply, 16'h0000);
      u_rdr.send(4'h3, 8'h00, sl, 1'b1);
      chk({id_reply, id_reply_data}, {!rep, tag_identifier});
      u_rdr.send(4'h3, 8'h00, sl, 1'b1);
      chk(id_reply, 16'h0000);
      u_rdr.send(4'h1, 8'h00, 4'h0, 1'b1);
      chk({id_reply, tag_state}, 16'h0022);
      u_rdr.send(4'h4, ~tag_identifier, 4'h0, 1'b1);
      chk(tag_state, 16'h0002);
      u_rdr.send(4'h4, tag_identifier, 4'h0, 1'b1);
      chk(tag_state, 16'h0004);
   end
   endtask
   task s_sel;
   begin
      for (i = 1; i < 10; i = i + 1)
         if (i < 4 || i > 5)
         begin
            u_rdr.send(i[3:0], 8'h00, 4'h0, 1'b1);
            chk({id_reply, mem_cmd_go, mem_cmd_go ? mem_cmd_code : 4'h0, tag_state},
               {i > 5, i > 5 ? i[3:0] : 4'h0, 5'h04});
         end
      u_rdr.send(4'h4, tag_identifier ^ 8'h80, 4'h0, 1'b1);
      chk(tag_state, 16'h0008);
      u_rdr.send(4'h1, 8'h00, 4'h0, 1'b1);
      chk({id_reply, tag_state}, 16'h0008);
      u_rdr.send(4'h4, tag_identifier, 4'h0, 1'b1);
      chk(tag_state, 16'h0004);
      u_rdr.send(4'h5, 8'h00, 4'h0, 1'b1);
      chk(tag_state, 16'h0010);
      for (i = 1; i < 10; i = i + 1)
      begin
         u_rdr.send(i[3:0], tag_identifier, 4'h0, 1'b1);
         chk({id_reply, mem_cmd_go, tag_state}, 16'h0010);
      end
   end
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      #1;
      chk(tag_state, 16'h0001);
      sys_rst = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      s_ready;
      s_inv;
      s_sel;
      sys_rst = 1'b1;
      @(posedge clk);
      #1;
      chk({id_reply, tag_state, tag_identifier}, 16'h0100);
      sys_rst = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk({id_reply, mem_cmd_go, tag_state}, 16'h0001);
      close_out;
   end
endmodule
